// ---- core/dac_data_latch_group_ctrl.sv ----
/*
 * Register file, data formatting, latch update and grouping for two converters.
 * Assumes an AHB-Lite master, timer compare outputs synchronous to core_clk,
 * and an analog core that takes the code and settings as levels.
 */
// How it works
// [R1] Straight binary: 0FFF is full scale at 12 bits, 0FF at 8 bits.
// [R2] Two's complement: 0800/0080 is zero, 0000 mid, 07FF/007F full scale.
// [R3] Two's complement becomes offset binary by flipping the active-width top bit.
// [R4] Writing one to the calibration start bit launches offset calibration.
// [R5] Hardware clears calibration start when the sequence ends; one means running.
// [R6] Software should set buffer drive before asking for calibration.
// [R7] Software should wait for calibration to end before using the output.
// [R8] Converter zero's group bit groups both; converter one's group bit ignored.
// [R9] When grouped, converter one's trigger selection updates both converters.
// [R10] Grouped use needs nonzero trigger selections and both conversion enables set.
// [R11] Grouped: no update until both sample registers written since the last.
// [R12] Grouped with nonzero selections: no update if either enable is clear.
// [R13] Grouped latches load together in one cycle, whatever interrupts occur.
// [R14] Data-ready flag sets when a latch loads with nonzero trigger selection.
// [R15] Data-ready flag never sets in transparent mode.
// [R16] Interrupt request when flag, its enable and global enable are set.
// [R17] Data-ready flag holds until software clears it.
// [R18] With a shared vector software checks both converter and transfer flags.
// [R19] All control and data bits are zero after power-on reset.
// [R20] Selection zero passes sample straight through on every write, enable ignored, except converter zero when grouped.
// [R21] Selection 2 or 3 loads on rising edge of timer compare outputs.
// [R22] At 8 bits, sample bits 11:8 are stored but ignored; bits 15:12 are dropped on write.
`timescale 1ns/1ps
`default_nettype none
module dac_data_latch_group_ctrl
	import dac_ctrl_pkg::*;
#(
	parameter int unsigned CAL_LEN = CAL_CYCLES
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic timer1_cmp1,
	input wire logic timer2_cmp2,
	output core_ctl_t core0,
	output core_ctl_t core1,
	output logic irq
);

	// Format the active-width code for the core
	function automatic logic [11:0] core_code(input logic [15:0] dat, input logic [15:0] ctl);
		logic [11:0] mask;
		logic [11:0] msb;
		mask = ctl[B_RES] ? MASK_8 : MASK_12;
		msb = ctl[B_RES] ? MSB_8 : MSB_12;
		core_code = dat[11:0] & mask; // R22 R1
		if (ctl[B_DF]) begin
			core_code = core_code ^ msb; // R3 R2
		end
	endfunction : core_code

	logic [15:0] ctl0_q, ctl1_q, dat0_q, dat1_q;
	logic [11:0] latch0_q, latch1_q;
	logic glob_ie_q;
	logic wr0_seen_q, wr1_seen_q;
	logic t1_q, t2_q;
	logic ap_wr_q;
	logic [11:0] ap_addr_q;
	logic [31:0] rdata_q;
	logic irq_q;
	core_ctl_t core0_q, core1_q;
	logic cal0_busy, cal1_busy;

	// Address phase decode
	wire logic ap_valid = hsel && hready && (htrans == HTRANS_NONSEQ);
	wire logic [11:0] ap_addr = haddr[11:0];
	wire logic wr_ctl0 = ap_wr_q && (ap_addr_q == ADDR_CTL0);
	wire logic wr_ctl1 = ap_wr_q && (ap_addr_q == ADDR_CTL1);
	wire logic wr_dat0 = ap_wr_q && (ap_addr_q == ADDR_DAT0);
	wire logic wr_dat1 = ap_wr_q && (ap_addr_q == ADDR_DAT1);
	wire logic wr_sys = ap_wr_q && (ap_addr_q == ADDR_SYS);
	wire logic [15:0] wdat = hwdata[15:0];

	// Trigger selection and grouping
	wire logic grouped = ctl0_q[B_GRP]; // R8
	wire logic [1:0] lsel0 = grouped ? ctl1_q[11:10] : ctl0_q[11:10]; // R9
	wire logic [1:0] lsel1 = ctl1_q[11:10];
	wire logic t1_rise = timer1_cmp1 && !t1_q;
	wire logic t2_rise = timer2_cmp2 && !t2_q;

	// Trigger event for a given selection; write-select uses the sample write itself
	function automatic logic trig_hit(input logic [1:0] sel, input logic wr_event, input logic t1,
		input logic t2);
		unique case (sel)
			LSEL_WRITE: trig_hit = wr_event;
			LSEL_TIMER1: trig_hit = t1; // R21
			LSEL_TIMER2: trig_hit = t2; // R21
			default: trig_hit = 1'b0;
		endcase
	endfunction : trig_hit

	// Grouped pair: both written since last update and both enabled
	wire logic both_written = (wr0_seen_q || wr_dat0) && (wr1_seen_q || wr_dat1); // R11
	wire logic grp_ready = both_written && ctl0_q[B_ENC] && ctl1_q[B_ENC]
		&& (ctl0_q[11:10] != LSEL_TRANSP) && (lsel1 != LSEL_TRANSP); // R12
	wire logic grp_load = grouped && grp_ready
		&& trig_hit(lsel1, both_written, t1_rise, t2_rise); // R13
	wire logic solo0_load = !grouped && (lsel0 != LSEL_TRANSP) && ctl0_q[B_ENC]
		&& trig_hit(lsel0, wr_dat0, t1_rise, t2_rise);
	wire logic solo1_load = !grouped && (lsel1 != LSEL_TRANSP) && ctl1_q[B_ENC]
		&& trig_hit(lsel1, wr_dat1, t1_rise, t2_rise);
	wire logic load0 = grp_load || solo0_load;
	wire logic load1 = grp_load || solo1_load;
	// Sample value as it will stand after this cycle's write
	wire logic [15:0] dat0_new = wr_dat0 ? (wdat & DAT_MASK) : dat0_q;
	wire logic [15:0] dat1_new = wr_dat1 ? (wdat & DAT_MASK) : dat1_q;
	wire logic transp0 = (lsel0 == LSEL_TRANSP) && !grouped;
	wire logic transp1 = (lsel1 == LSEL_TRANSP);

	// Flag set has priority over a software write of zero
	wire logic ifg0_set = load0 && (lsel0 != LSEL_TRANSP); // R14 R15
	wire logic ifg1_set = load1 && (lsel1 != LSEL_TRANSP); // R14 R15
	wire logic cal0_start = wr_ctl0 && wdat[B_CAL] && !cal0_busy; // R4
	wire logic cal1_start = wr_ctl1 && wdat[B_CAL] && !cal1_busy; // R4

	// Next control values: write, then hardware-owned flag and calibration bits
	function automatic logic [15:0] ctl_next(input logic [15:0] cur, input logic wr,
		input logic [15:0] wd, input logic ifg_set, input logic busy, input logic start);
		logic [15:0] v;
		v = wr ? wd : cur;
		v[B_IFG] = v[B_IFG] || ifg_set; // R17
		v[B_CAL] = busy || start; // R5
		ctl_next = v;
	endfunction : ctl_next

	// AHB address phase capture; always zero wait states
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ap_wr_q <= 1'b0;
			ap_addr_q <= 12'h000;
		end else begin
			ap_wr_q <= ap_valid && hwrite;
			ap_addr_q <= ap_addr;
		end
	end

	// Read data is registered at the address phase so it stands in the data phase
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_q <= 32'h0000_0000;
		end else if (ap_valid && !hwrite) begin
			unique case (ap_addr)
				ADDR_CTL0: rdata_q <= {16'h0000, ctl0_q};
				ADDR_CTL1: rdata_q <= {16'h0000, ctl1_q};
				ADDR_DAT0: rdata_q <= {16'h0000, dat0_q};
				ADDR_DAT1: rdata_q <= {16'h0000, dat1_q};
				ADDR_SYS: rdata_q <= {29'h0000_0000, cal1_busy, cal0_busy, glob_ie_q};
				default: rdata_q <= 32'h0000_0000;
			endcase
		end
	end

	// Control and sample registers
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctl0_q <= CTL_RESET; // R19
			ctl1_q <= CTL_RESET; // R19
			dat0_q <= 16'h0000; // R19
			dat1_q <= 16'h0000; // R19
			glob_ie_q <= 1'b0;
		end else begin
			ctl0_q <= ctl_next(ctl0_q, wr_ctl0, wdat, ifg0_set, cal0_busy, cal0_start);
			ctl1_q <= ctl_next(ctl1_q, wr_ctl1, wdat, ifg1_set, cal1_busy, cal1_start);
			dat0_q <= dat0_new;
			dat1_q <= dat1_new;
			if (wr_sys) glob_ie_q <= wdat[0];
		end
	end

	// Write tracking for the group, cleared on each grouped update
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wr0_seen_q <= 1'b0;
			wr1_seen_q <= 1'b0;
		end else if (grp_load || !grouped) begin
			wr0_seen_q <= 1'b0; // R11
			wr1_seen_q <= 1'b0;
		end else begin
			wr0_seen_q <= wr0_seen_q || wr_dat0;
			wr1_seen_q <= wr1_seen_q || wr_dat1;
		end
	end

	// Data latches and timer edge history
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			latch0_q <= 12'h000;
			latch1_q <= 12'h000;
			t1_q <= 1'b0;
			t2_q <= 1'b0;
		end else begin
			t1_q <= timer1_cmp1;
			t2_q <= timer2_cmp2;
			if (load0 || transp0) latch0_q <= dat0_new[11:0]; // R20 R13
			if (load1 || transp1) latch1_q <= dat1_new[11:0]; // R20 R13
		end
	end

	// Core-facing outputs, registered from the latches; in transparent mode the latch follows the sample and these follow a cycle later
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			core0_q <= '0;
			core1_q <= '0;
			irq_q <= 1'b0;
		end else begin
			core0_q <= '{core_code({4'h0, latch0_q}, ctl0_q), ctl0_q[B_IR] == 1'b0,
				ctl0_q[B_RES], ctl0_q[14:13], ctl0_q[B_OPS], ctl0_q[7:5], cal0_busy};
			core1_q <= '{core_code({4'h0, latch1_q}, ctl1_q), ctl1_q[B_IR] == 1'b0,
				ctl1_q[B_RES], ctl1_q[14:13], ctl1_q[B_OPS], ctl1_q[7:5], cal1_busy};
			irq_q <= glob_ie_q && ((ctl0_q[B_IFG] && ctl0_q[B_IE])
				|| (ctl1_q[B_IFG] && ctl1_q[B_IE])); // R16
		end
	end

	// One calibration sequencer per converter
	cal_sequencer #(.CYCLES(CAL_LEN)) u_cal0 (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.start(cal0_start),
		.busy(cal0_busy)
	);

	cal_sequencer #(.CYCLES(CAL_LEN)) u_cal1 (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.start(cal1_start),
		.busy(cal1_busy)
	);

	assign hreadyout = 1'b1; // Constant: never inserts wait states
	assign hresp = 1'b0;
	assign hrdata = rdata_q;
	assign core0 = core0_q;
	assign core1 = core1_q;
	assign irq = irq_q;

endmodule : dac_data_latch_group_ctrl
`default_nettype wire

// ---- common/dac_ctrl_pkg.sv ----
/*
 * Shared constants and carriers for the two-channel converter control block.
 * Assumes a 32-bit AHB-Lite register bus; each 16-bit register sits in the low half of one word.
 */
package dac_ctrl_pkg;

	// Printed register indexes; byte address is four times the index
	localparam logic [9:0] IDX_CTL0 = 10'h1C0;
	localparam logic [9:0] IDX_CTL1 = 10'h1C2;
	localparam logic [9:0] IDX_DAT0 = 10'h1C8;
	localparam logic [9:0] IDX_DAT1 = 10'h1CA;
	localparam logic [11:0] ADDR_CTL0 = {IDX_CTL0, 2'b00};
	localparam logic [11:0] ADDR_CTL1 = {IDX_CTL1, 2'b00};
	localparam logic [11:0] ADDR_DAT0 = {IDX_DAT0, 2'b00};
	localparam logic [11:0] ADDR_DAT1 = {IDX_DAT1, 2'b00};
	// Own status register: calibration busy bits and global enable
	localparam logic [11:0] ADDR_SYS = 12'h800;

	// Control field positions
	localparam int unsigned B_OPS = 15;
	localparam int unsigned B_SREF = 13;
	localparam int unsigned B_RES = 12;
	localparam int unsigned B_LSEL = 10;
	localparam int unsigned B_CAL = 9;
	localparam int unsigned B_IR = 8;
	localparam int unsigned B_AMP = 5;
	localparam int unsigned B_DF = 4;
	localparam int unsigned B_IE = 3;
	localparam int unsigned B_IFG = 2;
	localparam int unsigned B_ENC = 1;
	localparam int unsigned B_GRP = 0;

	localparam logic [15:0] CTL_RESET = 16'h0000;
	localparam logic [15:0] DAT_MASK = 16'h0FFF;
	localparam logic [11:0] MASK_12 = 12'hFFF;
	localparam logic [11:0] MASK_8 = 12'h0FF;
	localparam logic [11:0] MSB_12 = 12'h800;
	localparam logic [11:0] MSB_8 = 12'h080;

	// Load trigger selections
	localparam logic [1:0] LSEL_TRANSP = 2'h0;
	localparam logic [1:0] LSEL_WRITE = 2'h1;
	localparam logic [1:0] LSEL_TIMER1 = 2'h2;
	localparam logic [1:0] LSEL_TIMER2 = 2'h3;

	// Calibration duration
	localparam int unsigned CAL_TIME_US = 100;
	localparam int unsigned CLK_MHZ = 20;
	localparam int unsigned CAL_CYCLES = CAL_TIME_US * CLK_MHZ;

	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
	localparam logic [2:0] HSIZE_WORD = 3'b010;

	// Core-facing view of one converter
	typedef struct packed {
		logic [11:0] code;
		logic range_1x;
		logic resolution_8;
		logic [1:0] reference_select;
		logic output_pin_select;
		logic [2:0] buffer_drive_select;
		logic calibrate;
	} core_ctl_t;

endpackage : dac_ctrl_pkg

// ---- core/cal_sequencer.sv ----
/*
 * Offset calibration sequencer for one converter: busy from start until a fixed count runs out.
 * Assumes start is a one-cycle pulse from the register file.
 */
`timescale 1ns/1ps
`default_nettype none
module cal_sequencer
	import dac_ctrl_pkg::*;
#(
	parameter int unsigned CYCLES = CAL_CYCLES
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic start,
	output logic busy
);

	typedef enum logic {CAL_IDLE, CAL_RUN} cal_state_t;
	cal_state_t state_q;
	logic [15:0] count_q;
	wire logic done = (count_q == 16'(CYCLES - 1));

	// Count up the sequence; a new start while running is ignored
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= CAL_IDLE;
			count_q <= 16'h0000;
		end else begin
			unique case (state_q)
				CAL_IDLE: begin
					count_q <= 16'h0000;
					if (start) state_q <= CAL_RUN;
				end
				CAL_RUN: begin
					count_q <= count_q + 16'h0001;
					if (done) state_q <= CAL_IDLE;
				end
			endcase
		end
	end

	assign busy = (state_q == CAL_RUN);

endmodule : cal_sequencer
`default_nettype wire

// ---- tb/dac_ctrl_checker_assertions.sv ----
/* Port checker for the converter control block.
   Assumes one clock and an async active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module dac_ctrl_checker
	import dac_ctrl_pkg::*;
#(
	parameter int unsigned CAL_LEN = CAL_CYCLES
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic timer1_cmp1,
	input wire logic timer2_cmp2,
	input wire core_ctl_t core0,
	input wire core_ctl_t core1,
	input wire logic irq
);
	localparam int CAL_MAX = CAL_LEN + 2;
	logic [3:0] since_q;
	logic [15:0] cal_len_q;
	logic t1_q;
	logic t2_q;
	// Cycles since a write or timer rise; saturates so idle time cannot wrap it
	wire logic go = hsel & hready & (htrans == HTRANS_NONSEQ);
	wire logic cause = (go & hwrite) | (timer1_cmp1 & ~t1_q) | (timer2_cmp2 & ~t2_q);
	wire logic [3:0] since_d = cause ? 4'h0 : (since_q == 4'hF) ? since_q : since_q + 4'h1;
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			since_q <= 4'hF;
			cal_len_q <= 16'h0000;
			t1_q <= 1'b0;
			t2_q <= 1'b0;
		end else begin
			since_q <= since_d;
			// Length of the current busy run; a delay range cannot reach the full-size count
			cal_len_q <= core0.calibrate ? cal_len_q + 16'h0001 : 16'h0000;
			t1_q <= timer1_cmp1;
			t2_q <= timer2_cmp2;
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	a_resp_okay: assert property (hresp == 1'b0) else $error("error response");
	a_ready_high: assert property (hreadyout == 1'b1) else $error("wait state inserted");
	a_reset_clear: assert property ($fell(sys_rst) |-> core0.code == 12'h000
		&& core1.code == 12'h000 && irq == 1'b0) else $error("not clear after reset");
	a_cal_bounded: assert property (core0.calibrate |-> cal_len_q < 16'(CAL_MAX))
		else $error("calibration never ends");
	a_res8_masked: assert property (core0.resolution_8 && $past(core0.resolution_8)
		|-> core0.code[11:8] == 4'h0) else $error("8-bit code too wide");
	a_dat_upper: assert property (go && !hwrite && haddr[11:0] == ADDR_DAT0
		|=> hrdata[31:12] == 20'h00000) else $error("sample upper bits set");
	a_code_cause: assert property ($changed(core0.code) || $changed(core1.code)
		|-> since_q <= 4'h4) else $error("code moved without cause");
	a_irq_cause: assert property ($rose(irq) |-> since_q <= 4'h5) else $error("stray irq");
	c_irq: cover property ($rose(irq));
	c_cal: cover property ($rose(core0.calibrate));
	c_pair: cover property ($changed(core0.code) && $changed(core1.code));
endmodule : dac_ctrl_checker
bind dac_data_latch_group_ctrl dac_ctrl_checker #(.CAL_LEN(CAL_LEN)) u_chk (.core_clk,
	.sys_rst, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata,
	.timer1_cmp1, .timer2_cmp2, .core0, .core1, .irq);
`default_nettype wire

// ---- tb/dac_core_model.sv ----
/* Stand-in for the analog core: counts lone-converter code updates.
   Assumes codes are levels sampled on core_clk. */
`timescale 1ns/1ps
`default_nettype none
module dac_core_model
	import dac_ctrl_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire core_ctl_t core0,
	input wire core_ctl_t core1,
	output var int split
);
	logic [11:0] last0_q;
	logic [11:0] last1_q;
	// One output moving without the other would glitch a grouped pair
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			last0_q <= 12'h000;
			last1_q <= 12'h000;
			split <= 0;
		end else begin
			last0_q <= core0.code;
			last1_q <= core1.code;
			if ((last0_q != core0.code) != (last1_q != core1.code))
				split <= split + 1;
		end
	end
endmodule : dac_core_model
`default_nettype wire

// ---- tb/dac_data_latch_group_ctrl_tb.sv ----
/* Self-checking bench for the converter control block.
   Assumes the checker binds itself and the core model watches both codes. */
`timescale 1ns/1ps
`default_nettype none
module dac_data_latch_group_ctrl_tb
	import dac_ctrl_pkg::*;
;
	localparam int CAL = 8;
	logic core_clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic timer1_cmp1 = 1'b0, timer2_cmp2 = 1'b0;
	logic hreadyout, hresp, irq;
	wire logic hready = hreadyout;
	logic [31:0] hrdata;
	core_ctl_t core0, core1;
	int split, mismatches = 0, cmp_count = 0;
	always #25 core_clk = ~core_clk;
	dac_data_latch_group_ctrl #(.CAL_LEN(CAL)) dut (.core_clk, .sys_rst, .hsel, .haddr,
		.htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
		.timer1_cmp1, .timer2_cmp2, .core0, .core1, .irq);
	dac_core_model pm (.core_clk, .sys_rst, .core0, .core1, .split);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask : cyc
	// One single word; both phases wait on ready, read data taken at the closing edge
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= {20'h00000, a};
		hwrite <= w;
		htrans <= HTRANS_NONSEQ;
		hsize <= HSIZE_WORD;
		do @(posedge core_clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge core_clk); while (hready !== 1'b1);
		q = hrdata;
	endtask : bus
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr
	task automatic rc(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask : rc
	// Two-cycle compare pulse, then room for latch and core stages
	task automatic pulse(input logic second);
		timer1_cmp1 <= ~second;
		timer2_cmp2 <= second;
		cyc(2);
		timer1_cmp1 <= 1'b0;
		timer2_cmp2 <= 1'b0;
		cyc(4);
	endtask : pulse
	task automatic t_format;
		logic [15:0] ctl [7] = '{16'h0000, 16'h1000, 16'h0010, 16'h0010, 16'h0010, 16'h1010, 16'h1010};
		logic [11:0] dat [7] = '{12'hFFF, 12'h3FF, 12'h800, 12'h000, 12'h7FF, 12'h080, 12'h07F};
		logic [11:0] ex [7] = '{12'hFFF, 12'h0FF, 12'h000, 12'h800, 12'hFFF, 12'h000, 12'h0FF};
		for (int i = 0; i < 7; i++) begin
			wr(ADDR_CTL0, {16'h0000, ctl[i]});
			wr(ADDR_DAT0, {20'h00000, dat[i]});
			cyc(3);
			chk({20'h00000, core0.code}, {20'h00000, ex[i]});
		end
		rc(ADDR_CTL0, 32'h00001010);
	endtask : t_format
	task automatic t_calib;
		wr(ADDR_CTL0, 32'h00000040);
		wr(ADDR_CTL0, 32'h00000240);
		rc(ADDR_CTL0, 32'h00000240);
		chk({31'h0, core0.calibrate}, 32'h1);
		chk({29'h0, core0.buffer_drive_select}, 32'h2);
		chk({31'h0, core0.range_1x}, 32'h1);
		cyc(CAL + 4);
		rc(ADDR_CTL0, 32'h00000040);
	endtask : t_calib
	task automatic t_latch;
		wr(ADDR_SYS, 32'h1);
		wr(ADDR_CTL0, 32'h0000040A);
		wr(ADDR_DAT0, 32'h00000123);
		cyc(4);
		chk({20'h0, core0.code}, 32'h123);
		chk({31'h0, irq}, 32'h1);
		cyc(20);
		rc(ADDR_CTL0, 32'h0000040E);
		wr(ADDR_SYS, 32'h0);
		cyc(3);
		chk({31'h0, irq}, 32'h0);
		wr(ADDR_CTL0, 32'h0000040A);
		rc(ADDR_CTL0, 32'h0000040A);
	endtask : t_latch
	// Trigger changes go through a disabled step; no control field is locked while enabled
	task automatic t_timer;
		wr(ADDR_CTL0, 32'h0);
		wr(ADDR_CTL0, 32'h00000802);
		wr(ADDR_DAT0, 32'h000000AA);
		cyc(4);
		chk({20'h0, core0.code}, 32'h123);
		pulse(1'b0);
		chk({20'h0, core0.code}, 32'h0AA);
		wr(ADDR_CTL1, 32'h00000C02);
		wr(ADDR_DAT1, 32'h00000055);
		pulse(1'b0);
		chk({20'h0, core1.code}, 32'h000);
		pulse(1'b1);
		chk({20'h0, core1.code}, 32'h055);
	endtask : t_timer
	task automatic t_group;
		int n;
		wr(ADDR_CTL0, 32'h0);
		wr(ADDR_CTL0, 32'h00000403);
		n = split;
		wr(ADDR_DAT0, 32'h00000111);
		pulse(1'b1);
		chk({20'h0, core0.code}, 32'h0AA);
		wr(ADDR_DAT1, 32'h00000222);
		cyc(4);
		chk({20'h0, core1.code}, 32'h055);
		pulse(1'b1);
		chk({20'h0, core0.code}, 32'h111);
		chk({20'h0, core1.code}, 32'h222);
		chk(split, n);
		wr(ADDR_CTL1, 32'h00000C00);
		wr(ADDR_DAT0, 32'h00000333);
		wr(ADDR_DAT1, 32'h00000444);
		pulse(1'b1);
		chk({20'h0, core0.code}, 32'h111);
	endtask : t_group
	task automatic report_and_stop;
		$display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop
	initial begin
		cyc(10);
		sys_rst <= 1'b0;
		cyc(1);
		rc(ADDR_CTL0, 32'h0);
		rc(ADDR_CTL1, 32'h0);
		rc(ADDR_DAT1, 32'h0);
		rc(12'h004, 32'h0);
		t_format;
		t_calib;
		t_latch;
		t_timer;
		t_group;
		report_and_stop;
	end
	// A hang is cut off well past the two hundred or so cycles the run needs
	initial begin
		cyc(20000);
		mismatches++;
		report_and_stop;
	end
endmodule : dac_data_latch_group_ctrl_tb
`default_nettype wire
